// ==== hdl/rcs_cfg.svh ====
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
// Claimed register window, inclusive bounds.
`define RCS_WIN_LO      32'h0000_4000
`define RCS_WIN_HI      32'h0004_ffff
// Register offsets inside the window.
`define RCS_OFS_START   32'h0000_4030
`define RCS_OFS_TAIL    32'h0000_4034
`define RCS_OFS_HEAD    32'h0000_4038
`define RCS_OFS_CTL     32'h0000_403c
// Control register field: ring enable bit.
`define RCS_CTL_EN_BIT  0
// Reset values.
`define RCS_RST_PTR     32'h0000_0000
// Fetch geometry: dwords per line and lines held by the fetch buffer.
`define RCS_LINE_DW     16
`define RCS_LINE_BYTES  32'h0000_0040
`define RCS_FIFO_LINES  16
// Memory-interface opcodes handled by the streamer itself.
`define RCS_OP_NOP      6'h00
`define RCS_OP_USER_IRQ 6'h02
`define RCS_OP_CTX_IRQ  6'h03
`define RCS_OP_FLUSH    6'h04
`define RCS_OP_MULTI    6'h10
// Pipeline header codes, bits 28:16, of the partition and constant load commands; set per system.
`define RCS_HDR_FENCE   13'h0001
`define RCS_HDR_CONST   13'h0002
`endif

// ==== hdl/rcs_pkg.sv ====
`default_nettype none
package rcs_pkg;
	// Parser states.
	typedef enum logic [1:0] {RCS_P_HDR, RCS_P_BODY} rcs_pstate_t;
	// Client field of a header dword.
	typedef enum logic [2:0] {
		RCS_CL_MI   = 3'h0,
		RCS_CL_MISC = 3'h1,
		RCS_CL_2D   = 3'h2,
		RCS_CL_PIPE = 3'h3
	} rcs_client_t;
endpackage : rcs_pkg
`default_nettype wire

// ==== hdl/rcs_streamer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcs_cfg.svh"
// How it works
// - claim only addresses inside own window.
// - registers move as one dword per access.
// - enabling ring write kicks off fetch DMA.
// - each memory request asks one cache line.
// - request only when sixteen-line buffer has room.
// - DMA head copy advances per request.
// - requests stop when DMA head equals tail.
// - parser runs only on buffered valid dwords.
// - header decides engine or own parser.
// - forwarded packets drop their header dword.
// - head moves per command; equal means empty.
// - user, context interrupts, flush and no-op.
// - render mode routes clients zero to three.
// - codec mode accepts clients zero and three.
// - command length whole dwords from header.
// - partition change voids loaded constants.
module rcs_streamer
	import rcs_pkg::*;
#(
	parameter int RING_BYTES = 4096
)(
	// Clock, reset and enable.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// Register programming bus.
	input  wire logic        rpb_valid_in,
	input  wire logic        rpb_write_in,
	input  wire logic [31:0] rpb_addr_in,
	input  wire logic [31:0] rpb_wdata_in,
	output logic             rpb_ready_out,
	output logic             rpb_rvalid_out,
	output logic [31:0]      rpb_rdata_out,
	// Memory read port.
	output logic             mem_req_out,
	output logic [31:0]      mem_addr_out,
	input  wire logic        mem_gnt_in,
	input  wire logic        mem_rvalid_in,
	input  wire logic [31:0] mem_rdata_in,
	// Mode: high selects render routing, low codec routing.
	input  wire logic        render_mode_in,
	// Video engine packet port.
	output logic             ve_valid_out,
	output logic [31:0]      ve_data_out,
	output logic [2:0]       ve_client_out,
	output logic             ve_last_out,
	input  wire logic        ve_ready_in,
	// Events.
	output logic             user_irq_out,
	output logic             ctx_irq_out,
	output logic             ve_flush_out,
	output logic             cmd_err_out,
	output logic             ring_empty_out
);
	localparam int FD = `RCS_LINE_DW * `RCS_FIFO_LINES;   // Buffer depth in dwords.
	localparam int AW = $clog2(FD);
	localparam logic [31:0] RMASK = 32'(RING_BYTES - 1);
	// Total command length in dwords, decoded from the header.
	function automatic logic [16:0] cmd_len(input logic [31:0] h);
		logic [16:0] n;
		n = 17'h1;
		if (h[31:29] == RCS_CL_MI)
		begin
			if (h[28:23] >= `RCS_OP_MULTI)
				n = 17'(h[5:0]) + 17'h2;
		end
		else if (h[31:29] == RCS_CL_MISC)
			n = 17'(h[15:0]) + 17'h2;
		else if (h[31:29] == RCS_CL_2D || h[31:29] == RCS_CL_PIPE)
		begin
			if (!(h[31:29] == RCS_CL_PIPE && h[28:27] == 2'h1))
				n = 17'(h[7:0]) + 17'h2;
		end
		return n;
	endfunction : cmd_len
	// Programming registers and pointer copies.
	logic [31:0]     start_q, tail_q, head_q, dma_head_q;
	logic            en_q;
	// Fetch buffer storage, pointers and occupancy.
	logic [31:0]     buf_q [FD];
	logic [AW-1:0]   wp_q, rp_q;
	logic [AW:0]     cnt_q;
	logic [4:0]      outst_q;                           // Lines requested, not yet fully back.
	logic [3:0]      ret_q;                             // Dword index in returning line.
	// Parser state.
	rcs_pstate_t     ps_q;
	logic [16:0]     rem_q, len_q;
	logic            fwd_q;
	logic [2:0]      cli_q;
	logic            const_ok_q;                        // Constant entries loaded, not voided since.
	// Window decode and register selects.
	wire hit   = rpb_valid_in && rpb_addr_in >= `RCS_WIN_LO && rpb_addr_in <= `RCS_WIN_HI;
	wire wr    = hit && rpb_write_in;
	wire w_st  = wr && rpb_addr_in == `RCS_OFS_START;
	wire w_tl  = wr && rpb_addr_in == `RCS_OFS_TAIL;
	wire w_ctl = wr && rpb_addr_in == `RCS_OFS_CTL;
	wire [31:0] rd_val =
		(rpb_addr_in == `RCS_OFS_START) ? start_q :
		(rpb_addr_in == `RCS_OFS_TAIL)  ? tail_q  :
		(rpb_addr_in == `RCS_OFS_HEAD)  ? head_q  :
		(rpb_addr_in == `RCS_OFS_CTL)   ? {31'h0, en_q} : 32'h0;
	assign rpb_ready_out = 1'b1;
	// Room is counted in dwords held plus lines still in flight.
	wire [11:0] used  = 12'(cnt_q) + 12'(outst_q) * 12'(`RCS_LINE_DW);
	wire        room  = used + 12'(`RCS_LINE_DW) <= 12'(FD);
	wire        req   = ce_in && en_q && dma_head_q != tail_q && room;
	wire        grant = req && mem_gnt_in;
	assign mem_req_out  = req;
	assign mem_addr_out = start_q + dma_head_q;
	wire [31:0] dma_nxt = (dma_head_q + `RCS_LINE_BYTES) & RMASK;
	// Parser pop: only with data buffered and the output stage free.
	wire        ostall = ve_valid_out && !ve_ready_in;
	wire        pop    = ce_in && cnt_q != '0 && !ostall;
	wire [31:0] dw     = buf_q[rp_q];
	wire [2:0]  cli    = dw[31:29];
	wire [5:0]  op     = dw[28:23];
	wire [16:0] hlen   = cmd_len(dw);
	wire        acc    = render_mode_in ? (cli <= 3'h3)
	                                    : (cli == 3'h0 || cli == 3'h3);
	wire        hfwd   = acc && cli != 3'h0;
	wire        hpop   = pop && ps_q == RCS_P_HDR;
	wire        bpop   = pop && ps_q == RCS_P_BODY;
	wire        done   = (hpop && hlen == 17'h1) || (bpop && rem_q == 17'h1);
	wire [16:0] dlen   = hpop ? hlen : len_q;
	wire        push   = mem_rvalid_in && outst_q != '0;
	wire        line_b = push && ret_q == 4'hf;
	wire        hfence = hpop && acc && cli == 3'h3 && dw[28:16] == `RCS_HDR_FENCE;
	wire        hconst = hpop && acc && cli == 3'h3 && dw[28:16] == `RCS_HDR_CONST;
	// Register writes; a ring enable reloads the DMA head copy.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			start_q <= `RCS_RST_PTR;
			tail_q  <= `RCS_RST_PTR;
			en_q    <= 1'b0;
		end
		else if (ce_in)
		begin
			if (w_st)
				start_q <= rpb_wdata_in;
			if (w_tl)
				tail_q <= rpb_wdata_in & RMASK;
			if (w_ctl)
				en_q <= rpb_wdata_in[`RCS_CTL_EN_BIT];
		end
	end
	// Read answer one cycle after a claimed read.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rpb_rvalid_out <= 1'b0;
			rpb_rdata_out  <= 32'h0;
		end
		else if (ce_in)
		begin
			rpb_rvalid_out <= hit && !rpb_write_in;
			rpb_rdata_out  <= rd_val;
		end
	end
	// DMA head copy: reloaded from the ring head on a fresh enable only, else stepped.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			dma_head_q <= `RCS_RST_PTR;
		else if (ce_in)
		begin
			if (w_ctl && rpb_wdata_in[`RCS_CTL_EN_BIT] && !en_q)
				dma_head_q <= head_q;
			else if (grant)
				dma_head_q <= dma_nxt;
		end
	end
	// Buffer fill from returning lines and drain by the parser.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			outst_q <= '0;
			ret_q   <= '0;
		end
		else if (ce_in)
		begin
			wp_q    <= wp_q + AW'(push);
			ret_q   <= ret_q + 4'(push);
			rp_q    <= rp_q + AW'(pop);
			cnt_q   <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			outst_q <= outst_q + 5'(grant) - 5'(line_b);
		end
	end
	// Buffer storage has no reset.
	always_ff @(posedge clk_in)
	begin
		if (ce_in && push)
			buf_q[wp_q] <= mem_rdata_in;
	end
	// Parser: header decode, then body dwords forwarded or skipped.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ps_q  <= RCS_P_HDR;
			rem_q <= '0;
			len_q <= '0;
			fwd_q <= 1'b0;
			cli_q <= '0;
		end
		else if (pop)
		begin
			case (ps_q)
				RCS_P_HDR:
				begin
					len_q <= hlen;
					rem_q <= hlen - 17'h1;
					fwd_q <= hfwd;
					cli_q <= cli;
					if (hlen != 17'h1)
						ps_q <= RCS_P_BODY;
				end
				default:
				begin
					rem_q <= rem_q - 17'h1;
					if (rem_q == 17'h1)
						ps_q <= RCS_P_HDR;
				end
			endcase
		end
	end
	// Packet output stage: body dwords only.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ve_valid_out  <= 1'b0;
			ve_data_out   <= 32'h0;
			ve_client_out <= 3'h0;
			ve_last_out   <= 1'b0;
		end
		else if (ce_in && !ostall)
		begin
			ve_valid_out  <= bpop && fwd_q;
			ve_data_out   <= dw;
			ve_client_out <= cli_q;
			ve_last_out   <= rem_q == 17'h1;
		end
	end

	// Architectural head and own memory-interface commands.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			head_q       <= `RCS_RST_PTR;
			user_irq_out <= 1'b0;
			ctx_irq_out  <= 1'b0;
			ve_flush_out <= 1'b0;
			cmd_err_out  <= 1'b0;
			const_ok_q   <= 1'b0;
		end
		else if (ce_in)
		begin
			if (done)
				head_q <= (head_q + {13'h0, dlen, 2'h0}) & RMASK;
			user_irq_out <= hpop && acc && cli == 3'h0 && op == `RCS_OP_USER_IRQ;
			ctx_irq_out  <= hpop && acc && cli == 3'h0 && op == `RCS_OP_CTX_IRQ;
			ve_flush_out <= hpop && acc && cli == 3'h0 && op == `RCS_OP_FLUSH;
			cmd_err_out  <= hpop && !acc;
			const_ok_q   <= hconst || (const_ok_q && !hfence);
		end
	end
	assign ring_empty_out = head_q == tail_q;

	// Checks.
	property p_win;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && rpb_valid_in && !rpb_write_in && rpb_addr_in < `RCS_WIN_LO
			|=> !rpb_rvalid_out;
	endproperty
	a_win: assert property (p_win) else $error("Read outside window answered.");
	property p_room;
		@(posedge clk_in) disable iff (rst_in)
		mem_req_out |-> used <= 12'(FD - `RCS_LINE_DW);
	endproperty
	a_room: assert property (p_room) else $error("Request without buffer room.");
	property p_stop;
		@(posedge clk_in) disable iff (rst_in)
		dma_head_q == tail_q |-> !mem_req_out;
	endproperty
	a_stop: assert property (p_stop) else $error("Request at tail.");
	property p_step;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && grant && !w_ctl |=> dma_head_q == (($past(dma_head_q) + 32'h40) & RMASK);
	endproperty
	a_step: assert property (p_step) else $error("DMA head did not step a line.");
	property p_cap;
		@(posedge clk_in) disable iff (rst_in)
		cnt_q <= (AW+1)'(FD);
	endproperty
	a_cap: assert property (p_cap) else $error("Buffer overfilled.");
	property p_pop;
		@(posedge clk_in) disable iff (rst_in)
		pop |-> cnt_q != '0;
	endproperty
	a_pop: assert property (p_pop) else $error("Parser ran on empty buffer.");
	property p_nohdr;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && !ostall && hpop |=> !ve_valid_out;
	endproperty
	a_nohdr: assert property (p_nohdr) else $error("Header dword forwarded.");
	property p_head;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && hpop && hlen == 17'h1 |=> head_q == (($past(head_q) + 32'h4) & RMASK);
	endproperty
	a_head: assert property (p_head) else $error("Head not moved by one dword.");
	property p_route;
		@(posedge clk_in) disable iff (rst_in)
		ve_valid_out |-> ve_client_out != 3'h0 && ve_client_out <= 3'h3;
	endproperty
	a_route: assert property (p_route) else $error("Bad client forwarded.");
	c_fetch: cover property (@(posedge clk_in) grant ##[1:20] line_b);
	c_fwd:   cover property (@(posedge clk_in) ve_valid_out && ve_ready_in && ve_last_out);
	c_irq:   cover property (@(posedge clk_in) user_irq_out);
	c_full:  cover property (@(posedge clk_in) en_q && !room);
	c_void:  cover property (@(posedge clk_in) hfence ##1 !const_ok_q);
endmodule : rcs_streamer
`default_nettype wire

// ==== testbench/rcs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Memory side: grants at once and returns each line as 16 dwords in order.
module rcs_mem_model (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Request side.
	input  wire logic        mem_req_in,
	input  wire logic [31:0] mem_addr_in,
	input  wire logic        slow_in,
	// Answer side.
	output logic             mem_gnt_out,
	output logic             mem_rvalid_out,
	output logic [31:0]      mem_rdata_out
);
	logic [31:0] mem [0:63];  // Ring image, filled by the bench.
	logic [31:0] line_q [$];  // Accepted line addresses, oldest first.
	logic [3:0]  beat_q;      // Dword within the current line.
	logic        gap_q;       // Idle cycle toggle for slow answers.
	// Every request is taken in the cycle it is raised.
	assign mem_gnt_out = mem_req_in;
	// Lines return in request order; idle data inverts the previous output on each idle cycle.
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			line_q.delete();
			beat_q <= 4'h0;
			gap_q <= 1'b0;
			mem_rvalid_out <= 1'b0;
			mem_rdata_out <= 32'h0;
		end
		else
		begin
			if (mem_req_in && mem_gnt_out)
				line_q.push_back(mem_addr_in);
			gap_q <= slow_in && !gap_q;
			if (line_q.size() != 0 && !gap_q)
			begin
				mem_rvalid_out <= 1'b1;
				mem_rdata_out <= mem[{line_q[0][7:6], beat_q}];
				beat_q <= beat_q + 4'h1;
				if (beat_q == 4'hf)
					void'(line_q.pop_front());
			end
			else
			begin
				mem_rvalid_out <= 1'b0;
				mem_rdata_out <= ~mem_rdata_out;
			end
		end
	end
endmodule : rcs_mem_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcs_cfg.svh"
// Self-checking bench for the ring command streamer.
module tb_top;
	logic        clk_in, rst_in, rpb_valid, rpb_write, render_mode, ve_ready, stall, slow;
	logic [31:0] rpb_addr, rpb_wdata, rd_data, ve_q [$];
	logic        rd_ok;
	logic [2:0]  last_client;  // Client of the last forwarded dword.
	wire logic        rpb_ready, rpb_rvalid, mem_req, mem_gnt, mem_rvalid, ve_valid, ve_last;
	wire logic        user_irq, ctx_irq, ve_flush, cmd_err, ring_empty;
	wire logic [31:0] rpb_rdata, mem_addr, mem_rdata, ve_data;
	wire logic [2:0]  ve_client;
	int fail_count, total_checks, cycles, n_last, n_user, n_ctx, n_flush, n_err;
	rcs_streamer #(.RING_BYTES(4096)) rcs_streamer_i (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(1'b1), .rpb_valid_in(rpb_valid), .rpb_write_in(rpb_write),
		.rpb_addr_in(rpb_addr), .rpb_wdata_in(rpb_wdata), .rpb_ready_out(rpb_ready),
		.rpb_rvalid_out(rpb_rvalid), .rpb_rdata_out(rpb_rdata), .mem_req_out(mem_req),
		.mem_addr_out(mem_addr), .mem_gnt_in(mem_gnt), .mem_rvalid_in(mem_rvalid),
		.mem_rdata_in(mem_rdata), .render_mode_in(render_mode), .ve_valid_out(ve_valid),
		.ve_data_out(ve_data), .ve_client_out(ve_client), .ve_last_out(ve_last),
		.ve_ready_in(ve_ready), .user_irq_out(user_irq), .ctx_irq_out(ctx_irq),
		.ve_flush_out(ve_flush), .cmd_err_out(cmd_err), .ring_empty_out(ring_empty));
	rcs_mem_model rcs_mem_model_i (.clk_in(clk_in), .rst_in(rst_in), .mem_req_in(mem_req),
		.mem_addr_in(mem_addr), .slow_in(slow), .mem_gnt_out(mem_gnt),
		.mem_rvalid_out(mem_rvalid), .mem_rdata_out(mem_rdata));
	// Free-running 100 MHz clock.
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Records packets and event pulses; also cuts a hang short.
	always @(posedge clk_in)
	begin
		cycles++;
		if (ve_valid && ve_ready)
		begin
			ve_q.push_back(ve_data);
			last_client = ve_client;
			n_last += ve_last;
		end
		n_user += user_irq;
		n_ctx += ctx_irq;
		n_flush += ve_flush;
		n_err += cmd_err;
		if (cycles == 5000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	// The engine side stalls every other cycle when asked to.
	always @(negedge clk_in)
		ve_ready <= stall ? ~ve_ready : 1'b1;
	// Compares one value with its expectation.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Clears the event records between scenarios.
	task automatic clr();
		ve_q.delete();
		{n_last, n_user, n_ctx, n_flush, n_err} = '0;
	endtask : clr
	// One register write, launched at the next falling edge so that two accesses
	// never share a time step; the bus takes it at the rising edge after.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_in);
		{rpb_valid, rpb_write, rpb_addr, rpb_wdata} = {2'b11, a, d};
		@(negedge clk_in);
		rpb_valid = 1'b0;
	endtask : wr
	// One register read; the answer stands only in the cycle after the taking
	// edge, so it is picked up at the falling edge inside that cycle.
	task automatic rd(input logic [31:0] a);
		@(negedge clk_in);
		{rpb_valid, rpb_write, rpb_addr} = {2'b10, a};
		@(negedge clk_in);
		rd_ok = rpb_rvalid;
		rd_data = rpb_rdata;
		rpb_valid = 1'b0;
	endtask : rd
	// Waits for the single line request, then sees the DMA fall silent.
	task automatic fetch_line(input logic [31:0] exp_addr);
		for (int i = 0; i < 50 && !mem_req; i++)
			@(negedge clk_in);
		chk(mem_addr, exp_addr);
		@(negedge clk_in);
		chk(32'(mem_req), 32'h0);
		for (int i = 0; i < 400 && !ring_empty; i++)
			@(negedge clk_in);
		repeat (8) @(negedge clk_in);
	endtask : fetch_line
	// Idle state straight after reset.
	task automatic t_reset();
		chk(32'(ring_empty), 32'h1);
		chk(32'(mem_req), 32'h0);
		chk(32'(rpb_ready), 32'h1);
		$display("t_reset done");
	endtask : t_reset
	// Accesses outside the window are ignored, inside are answered.
	task automatic t_window();
		wr(32'h0005_4034, 32'h0000_0040);
		rd(32'h0000_3038);
		chk(32'(rd_ok), 32'h0);
		rd(32'h0005_0038);
		chk(32'(rd_ok), 32'h0);
		rd(`RCS_OFS_TAIL);
		chk(32'(rd_ok), 32'h1);
		chk(rd_data, 32'h0);
		$display("t_window done");
	endtask : t_window
	// Render routing: a packet, a user interrupt and a reserved client.
	task automatic t_render();
		clr();
		for (int i = 0; i < 64; i++)
			rcs_mem_model_i.mem[i] = 32'h0;
		rcs_mem_model_i.mem[0] = 32'h6000_0001;
		rcs_mem_model_i.mem[1] = 32'h1111_0001;
		rcs_mem_model_i.mem[2] = 32'h2222_0002;
		rcs_mem_model_i.mem[3] = 32'h0100_0000;
		rcs_mem_model_i.mem[4] = 32'ha000_0000;
		wr(`RCS_OFS_START, 32'h0000_1000);
		wr(`RCS_OFS_TAIL, 32'h0000_0040);
		wr(`RCS_OFS_CTL, 32'h0000_0001);
		fetch_line(32'h0000_1000);
		chk(32'(ve_q.size()), 32'h2);
		chk(ve_q[0], 32'h1111_0001);
		chk(ve_q[1], 32'h2222_0002);
		chk(32'(n_last), 32'h1);
		chk(32'(last_client), 32'h3);
		chk(32'(n_user), 32'h1);
		chk(32'(n_err), 32'h1);
		rd(`RCS_OFS_HEAD);
		chk(rd_data, 32'h0000_0040);
		$display("t_render done");
	endtask : t_render
	// Codec routing with slow memory and a stalling engine.
	task automatic t_codec();
		clr();
		{render_mode, slow, stall} = 3'b011;
		rcs_mem_model_i.mem[16] = 32'h2000_0000;
		rcs_mem_model_i.mem[18] = 32'h4000_0000;
		rcs_mem_model_i.mem[20] = 32'h0180_0000;
		rcs_mem_model_i.mem[21] = 32'h0200_0000;
		rcs_mem_model_i.mem[22] = 32'h6000_0000;
		rcs_mem_model_i.mem[23] = 32'h0000_cafe;
		// The ring is still enabled, so the tail bump alone restarts the fetch.
		wr(`RCS_OFS_TAIL, 32'h0000_0080);
		fetch_line(32'h0000_1040);
		chk(32'(n_err), 32'h2);
		chk(32'(n_ctx), 32'h1);
		chk(32'(n_flush), 32'h1);
		chk(32'(ve_q.size()), 32'h1);
		chk(ve_q[0], 32'h0000_cafe);
		chk(32'(n_last), 32'h1);
		rd(`RCS_OFS_HEAD);
		chk(rd_data, 32'h0000_0080);
		$display("t_codec done");
	endtask : t_codec
	// Prints the counts and the verdict, then ends the run.
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// Main sequence: reset for three cycles, then the scenarios.
	initial
	begin
		{stall, slow, render_mode, rpb_valid, rpb_write} = 5'b00100;
		{rpb_addr, rpb_wdata} = '0;
		{fail_count, total_checks, cycles} = '0;
		rst_in = 1'b1;
		clr();
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		t_reset();
		t_window();
		t_render();
		t_codec();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
